// ==== logic/ais_pkg.sv ====
// Shared constants and carrier types for the identification and status register bank
package ais_pkg;

  localparam int AIS_AW = 6;
  localparam int AIS_DW = 16;

  localparam logic [AIS_AW-1:0] OFS_IDENT = 6'h00;
  localparam logic [AIS_AW-1:0] OFS_STATUS = 6'h01;
  localparam logic [AIS_AW-1:0] OFS_MODE = 6'h02;
  localparam logic [AIS_AW-1:0] OFS_CH2_GCAL_HI = 6'h16;
  localparam logic [AIS_AW-1:0] OFS_CH2_GCAL_LO = 6'h17;
  localparam logic [AIS_AW-1:0] OFS_CH3_INPUT_CONFIG = 6'h18;
  localparam logic [AIS_AW-1:0] OFS_CH3_OCAL_HI = 6'h19;
  localparam logic [AIS_AW-1:0] OFS_CH3_OCAL_LO = 6'h1A;
  localparam logic [AIS_AW-1:0] OFS_CH3_GCAL_HI = 6'h1B;
  localparam logic [AIS_AW-1:0] OFS_CH3_GCAL_LO = 6'h1C;
  localparam logic [AIS_AW-1:0] OFS_REGISTER_MAP_CHECKSUM = 6'h3E;
  localparam logic [AIS_AW-1:0] OFS_RESERVED_TOP = 6'h3F;

  // Identification word layout
  localparam logic [3:0] ID_UPPER_VAL = 4'h4;
  localparam logic [3:0] ID_CHANNEL_COUNT = 4'h4;
  // Arbitrary value for the version byte
  localparam logic [7:0] ID_VERSION_DEFAULT = 8'h5A;

  // Status and mode bit positions
  localparam int ST_LOCK = 15;
  localparam int ST_RESYNC = 14;
  localparam int ST_REGMAP = 13;
  localparam int ST_CRC_ERR = 12;
  localparam int ST_CRC_TYPE = 11;
  localparam int ST_RESET = 10;
  localparam int ST_WLEN_LSB = 8;
  localparam int MODE_RESET_BIT = 10;

  // Reset values and write masks
  localparam logic [AIS_DW-1:0] STATUS_RESET = 16'h0500;
  localparam logic [1:0] WLEN_RESET = 2'h1;
  localparam logic [AIS_DW-1:0] GCAL_HI_RESET = 16'h8000;
  localparam logic [AIS_DW-1:0] CAL_RESET = 16'h0000;
  localparam logic [AIS_DW-1:0] LO_WRITE_MASK = 16'hFF00;
  localparam logic [AIS_DW-1:0] CFG_WRITE_MASK = 16'h0003;
  localparam logic [AIS_DW-1:0] FULL_WRITE_MASK = 16'hFFFF;
  localparam logic [AIS_DW-1:0] ZERO_WORD = 16'h0000;

  typedef enum logic [1:0] {
    WL_16 = 2'h0,
    WL_24 = 2'h1,
    WL_32_ZERO_PAD = 2'h2,
    WL_32_SIGN_EXT = 2'h3
  } ais_word_size_t;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [AIS_AW-1:0] addr;
    logic [AIS_DW-1:0] wdata;
  } ais_req_t;

  typedef struct packed {
    logic lock;
    logic resync_event_flag;
    logic regmap_changed;
    logic crc_err;
    logic crc_type;
    logic reset_seen;
    ais_word_size_t output_word_size;
    logic [3:0] new_sample;
  } ais_status_t;

endpackage : ais_pkg

// ==== logic/ais_flag.sv ====
// Sticky event flag where a set in the same cycle beats a clear
`timescale 1ns/100ps
module ais_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic set, // Event pulse
  input wire logic clr, // Clear pulse
  output logic flag_q // Sticky flag
);

  logic flag_d;

  always_comb
  begin
    flag_d = flag_q;
    if (clr)
    begin
      flag_d = 1'b0;
    end
    // Set last so a coinciding event is never lost
    if (set)
    begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q <= RESET_VAL;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

endmodule : ais_flag

// ==== logic/ais_word.sv ====
// One host-writable 16-bit register with a write mask on implemented bits
`timescale 1ns/100ps
module ais_word
  import ais_pkg::*;
#(
  parameter logic [AIS_DW-1:0] RESET_VAL = 16'h0000,
  parameter logic [AIS_DW-1:0] WR_MASK = 16'hFFFF
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic we, // Write strobe for this word
  input wire logic [AIS_DW-1:0] wdata, // Write data
  output logic [AIS_DW-1:0] value_q // Stored value
);

  logic [AIS_DW-1:0] value_d;

  always_comb
  begin
    value_d = value_q;
    if (we)
    begin
      // Reserved bits stay at zero whatever is written
      value_d = wdata & WR_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      value_q <= RESET_VAL;
    end
    else
    begin
      value_q <= value_d;
    end
  end

endmodule : ais_word

// ==== logic/ais_regs.sv ====
// Identification, status and calibration tail register bank
// How it works
// - Identification channel-count field always reads 0100b, four channels.
// - Status bit 15 follows the serial interface lock state.
// - Status bit 14 sets on every converter resynchronization.
// - Status bit 13 reads 1 when computed register-map checksum changed.
// - Status bit 12 sets after an input checksum error.
// - Status bit 11 shows checksum polynomial: 0 CCITT, 1 ANSI.
// - Status bit 10 shows a reset occurred; it resets to 1.
// - Writing 0 to mode bit 10 clears the reset status flag.
// - Status bits 9:8 report output word length selection.
// - Status bits 3:0 flag new conversion data per channel.
// - Status reads 0500h straight after reset.
`timescale 1ns/100ps
module ais_regs
  import ais_pkg::*;
#(
  parameter logic [7:0] ID_VERSION = ID_VERSION_DEFAULT
) (
  input wire logic clk, // System clock, 20 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic rd_en, // Register read request from frame decoder
  input wire logic wr_en, // Register write request from frame decoder
  input wire logic [AIS_AW-1:0] addr, // Register address
  input wire logic [AIS_DW-1:0] wdata, // Write data
  input wire logic spi_locked, // Serial interface lock level
  input wire logic resync_pulse, // Converter resynchronized
  input wire logic crc_err_pulse, // Input frame checksum failed
  input wire logic crc_type_sel, // Selected checksum polynomial
  input wire logic [1:0] word_size_sel, // Selected output word length
  input wire logic [AIS_DW-1:0] register_map_checksum, // Computed register-map checksum
  input wire logic register_map_checksum_valid, // Checksum recomputed this cycle
  input wire logic [3:0] sample_pulse, // New conversion result per channel
  input wire logic [3:0] sample_taken, // Channel result read by host
  output logic [AIS_DW-1:0] rd_data_q, // Read data
  output logic rd_valid_q, // Read data valid pulse
  output logic [AIS_DW-1:0] status_q, // Status word mirror
  output logic [AIS_DW-1:0] ch2_gain_cal_high_q, // Channel 2 gain cal upper
  output logic [AIS_DW-1:0] ch2_gain_cal_low_q, // Channel 2 gain cal lower
  output logic [1:0] ch3_input_select_q, // Channel 3 input select
  output logic [AIS_DW-1:0] ch3_offset_cal_upper_q, // Channel 3 offset cal upper
  output logic [AIS_DW-1:0] ch3_offset_cal_low_q, // Channel 3 offset cal lower
  output logic [AIS_DW-1:0] ch3_gain_cal_upper_q, // Channel 3 gain cal upper
  output logic [AIS_DW-1:0] ch3_gain_cal_low_q // Channel 3 gain cal lower
);

  ais_req_t req;
  ais_status_t st;
  logic status_read;
  logic reset_clear;
  logic regmap_diff;
  logic resync_flag;
  logic regmap_flag;
  logic crc_err_flag;
  logic reset_flag;
  logic [3:0] new_sample_flag;
  logic [AIS_DW-1:0] ch3_input_config_word;

  // Sampled copies of levels so the status word comes from flops
  logic lock_q;
  logic lock_d;
  logic crc_type_q;
  logic crc_type_d;
  logic [1:0] word_size_q;
  logic [1:0] word_size_d;

  // Checksum change tracking
  logic [AIS_DW-1:0] crc_last_q;
  logic [AIS_DW-1:0] crc_last_d;
  logic crc_base_q;
  logic crc_base_d;

  // Read port
  logic [AIS_DW-1:0] rd_data_d;
  logic rd_valid_d;
  logic [AIS_DW-1:0] status_d;

  assign req.rd_en = rd_en;
  assign req.wr_en = wr_en;
  assign req.addr = addr;
  assign req.wdata = wdata;

  // Reading status acknowledges the resync, register-map and checksum error flags
  assign status_read = req.rd_en && (req.addr == OFS_STATUS);
  // Mode register lives elsewhere; only its reset-flag clear is seen here
  assign reset_clear = req.wr_en && (req.addr == OFS_MODE)
    && !req.wdata[MODE_RESET_BIT];
  // First checksum after reset only sets the baseline
  assign regmap_diff = register_map_checksum_valid && crc_base_q
    && (register_map_checksum != crc_last_q);

  ais_flag #(
    .RESET_VAL(1'b0)
  ) u_resync_flag (
    .clk(clk),
    .rst_n(rst_n),
    .set(resync_pulse),
    .clr(status_read),
    .flag_q(resync_flag)
  );

  ais_flag #(
    .RESET_VAL(1'b0)
  ) u_regmap_flag (
    .clk(clk),
    .rst_n(rst_n),
    .set(regmap_diff),
    .clr(status_read),
    .flag_q(regmap_flag)
  );

  ais_flag #(
    .RESET_VAL(1'b0)
  ) u_crc_err_flag (
    .clk(clk),
    .rst_n(rst_n),
    .set(crc_err_pulse),
    .clr(status_read),
    .flag_q(crc_err_flag)
  );

  // A reset is itself the event, hence the set reset value
  ais_flag #(
    .RESET_VAL(1'b1)
  ) u_reset_flag (
    .clk(clk),
    .rst_n(rst_n),
    .set(1'b0),
    .clr(reset_clear),
    .flag_q(reset_flag)
  );

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_sample
      ais_flag #(
        .RESET_VAL(1'b0)
      ) u_new_sample (
        .clk(clk),
        .rst_n(rst_n),
        .set(sample_pulse[ch]),
        .clr(sample_taken[ch]),
        .flag_q(new_sample_flag[ch])
      );
    end
  endgenerate

  ais_word #(
    .RESET_VAL(GCAL_HI_RESET),
    .WR_MASK(FULL_WRITE_MASK)
  ) u_ch2_gcal_hi (
    .clk(clk),
    .rst_n(rst_n),
    .we(req.wr_en && (req.addr == OFS_CH2_GCAL_HI)),
    .wdata(req.wdata),
    .value_q(ch2_gain_cal_high_q)
  );

  ais_word #(
    .RESET_VAL(CAL_RESET),
    .WR_MASK(LO_WRITE_MASK)
  ) u_ch2_gcal_lo (
    .clk(clk),
    .rst_n(rst_n),
    .we(req.wr_en && (req.addr == OFS_CH2_GCAL_LO)),
    .wdata(req.wdata),
    .value_q(ch2_gain_cal_low_q)
  );

  ais_word #(
    .RESET_VAL(CAL_RESET),
    .WR_MASK(CFG_WRITE_MASK)
  ) u_ch3_input_config (
    .clk(clk),
    .rst_n(rst_n),
    .we(req.wr_en && (req.addr == OFS_CH3_INPUT_CONFIG)),
    .wdata(req.wdata),
    .value_q(ch3_input_config_word)
  );

  ais_word #(
    .RESET_VAL(CAL_RESET),
    .WR_MASK(FULL_WRITE_MASK)
  ) u_ch3_ocal_hi (
    .clk(clk),
    .rst_n(rst_n),
    .we(req.wr_en && (req.addr == OFS_CH3_OCAL_HI)),
    .wdata(req.wdata),
    .value_q(ch3_offset_cal_upper_q)
  );

  ais_word #(
    .RESET_VAL(CAL_RESET),
    .WR_MASK(LO_WRITE_MASK)
  ) u_ch3_ocal_lo (
    .clk(clk),
    .rst_n(rst_n),
    .we(req.wr_en && (req.addr == OFS_CH3_OCAL_LO)),
    .wdata(req.wdata),
    .value_q(ch3_offset_cal_low_q)
  );

  ais_word #(
    .RESET_VAL(GCAL_HI_RESET),
    .WR_MASK(FULL_WRITE_MASK)
  ) u_ch3_gcal_hi (
    .clk(clk),
    .rst_n(rst_n),
    .we(req.wr_en && (req.addr == OFS_CH3_GCAL_HI)),
    .wdata(req.wdata),
    .value_q(ch3_gain_cal_upper_q)
  );

  ais_word #(
    .RESET_VAL(CAL_RESET),
    .WR_MASK(LO_WRITE_MASK)
  ) u_ch3_gcal_lo (
    .clk(clk),
    .rst_n(rst_n),
    .we(req.wr_en && (req.addr == OFS_CH3_GCAL_LO)),
    .wdata(req.wdata),
    .value_q(ch3_gain_cal_low_q)
  );

  // Mode levels and checksum baseline
  always_comb
  begin
    lock_d = spi_locked;
    crc_type_d = crc_type_sel;
    word_size_d = word_size_sel;
    crc_last_d = crc_last_q;
    crc_base_d = crc_base_q;
    if (register_map_checksum_valid)
    begin
      crc_last_d = register_map_checksum;
      crc_base_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_q <= 1'b0;
      crc_type_q <= 1'b0;
      word_size_q <= WLEN_RESET;
      crc_last_q <= ZERO_WORD;
      crc_base_q <= 1'b0;
    end
    else
    begin
      lock_q <= lock_d;
      crc_type_q <= crc_type_d;
      word_size_q <= word_size_d;
      crc_last_q <= crc_last_d;
      crc_base_q <= crc_base_d;
    end
  end

  always_comb
  begin
    st.lock = lock_q;
    st.resync_event_flag = resync_flag;
    st.regmap_changed = regmap_flag;
    st.crc_err = crc_err_flag;
    st.crc_type = crc_type_q;
    st.reset_seen = reset_flag;
    st.output_word_size = ais_word_size_t'(word_size_q);
    st.new_sample = new_sample_flag;
  end

  // Read path; identification and status have no write decode at all
  always_comb
  begin
    status_d = {st.lock, st.resync_event_flag, st.regmap_changed, st.crc_err,
      st.crc_type, st.reset_seen, st.output_word_size, 4'h0, st.new_sample};
    rd_valid_d = req.rd_en;
    rd_data_d = rd_data_q;
    if (req.rd_en)
    begin
      case (req.addr)
        OFS_IDENT: rd_data_d = {ID_UPPER_VAL, ID_CHANNEL_COUNT, ID_VERSION};
        OFS_STATUS: rd_data_d = status_d;
        OFS_CH2_GCAL_HI: rd_data_d = ch2_gain_cal_high_q;
        OFS_CH2_GCAL_LO: rd_data_d = ch2_gain_cal_low_q;
        OFS_CH3_INPUT_CONFIG: rd_data_d = ch3_input_config_word;
        OFS_CH3_OCAL_HI: rd_data_d = ch3_offset_cal_upper_q;
        OFS_CH3_OCAL_LO: rd_data_d = ch3_offset_cal_low_q;
        OFS_CH3_GCAL_HI: rd_data_d = ch3_gain_cal_upper_q;
        OFS_CH3_GCAL_LO: rd_data_d = ch3_gain_cal_low_q;
        OFS_REGISTER_MAP_CHECKSUM: rd_data_d = crc_last_q;
        default: rd_data_d = ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_q <= ZERO_WORD;
      rd_valid_q <= 1'b0;
      status_q <= STATUS_RESET;
    end
    else
    begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      status_q <= status_d;
    end
  end

  // Field view of the channel 3 configuration word
  assign ch3_input_select_q = ch3_input_config_word[1:0];

endmodule : ais_regs

// ==== tb/ais_regs_props.sv ====
// Checker for the identification and status register bank
`timescale 1ns/100ps
module ais_regs_props
  import ais_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic rd_en, // Read strobe
  input wire logic wr_en, // Write strobe
  input wire logic [AIS_AW-1:0] addr, // Address
  input wire logic [AIS_DW-1:0] wdata, // Write data
  input wire logic spi_locked, // Lock level
  input wire logic resync_pulse, // Resync event
  input wire logic crc_err_pulse, // Checksum error event
  input wire logic crc_type_sel, // Polynomial select
  input wire logic [1:0] word_size_sel, // Word length select
  input wire logic [3:0] sample_pulse, // New sample events
  input wire logic [AIS_DW-1:0] rd_data_q, // Read data
  input wire logic rd_valid_q, // Read answer
  input wire logic [AIS_DW-1:0] status_q // Status mirror
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Event flop plus status mirror: two edges to show
  sequence s_shows(logic f);
    ##2 f;
  endsequence

  // Level inputs pass an input flop and the status mirror: two edges of lag
  a_id_count: assert property (rd_en && addr == OFS_IDENT
    |=> rd_valid_q && rd_data_q[15:8] == 8'h44)
    else $error("identification read wrong");
  a_lock_follow: assert property ($past(rst_n) && $past(rst_n, 2)
    |-> status_q[ST_LOCK] == $past(spi_locked, 2))
    else $error("lock bit does not follow input");
  a_resync_set: assert property (resync_pulse |-> s_shows(status_q[ST_RESYNC]))
    else $error("resync flag not set");
  a_crc_err_set: assert property (crc_err_pulse |-> s_shows(status_q[ST_CRC_ERR]))
    else $error("checksum error flag not set");
  a_crc_type: assert property ($past(rst_n) && $past(rst_n, 2)
    |-> status_q[ST_CRC_TYPE] == $past(crc_type_sel, 2))
    else $error("checksum type bit wrong");
  a_reset_clear: assert property (wr_en && addr == OFS_MODE
    && !wdata[MODE_RESET_BIT] |-> s_shows(!status_q[ST_RESET]))
    else $error("reset flag not cleared");
  a_word_size: assert property ($past(rst_n) && $past(rst_n, 2)
    |-> status_q[9:8] == $past(word_size_sel, 2))
    else $error("word size bits wrong");
  a_new_sample: assert property (|sample_pulse |-> ##2
    (status_q[3:0] & $past(sample_pulse, 2)) == $past(sample_pulse, 2))
    else $error("new sample flag not set");
  a_reset_value: assert property ($rose(rst_n) |-> status_q == 16'h0500)
    else $error("status reset value wrong");
endmodule : ais_regs_props

bind ais_regs ais_regs_props u_props (.clk(clk), .rst_n(rst_n), .rd_en(rd_en), .wr_en(wr_en),
  .addr(addr), .wdata(wdata), .spi_locked(spi_locked), .resync_pulse(resync_pulse),
  .crc_err_pulse(crc_err_pulse), .crc_type_sel(crc_type_sel), .word_size_sel(word_size_sel),
  .sample_pulse(sample_pulse), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
  .status_q(status_q));

// ==== tb/ais_host.sv ====
// Host model issuing register reads and writes
`timescale 1ns/100ps
module ais_host
  import ais_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rd_valid_q, // Read answer strobe
  input wire logic [AIS_DW-1:0] rd_data_q, // Read answer data
  output ais_req_t req // Request bundle
);
  initial req = '0;

  // Released fields show the inverse so stale values never pass
  task automatic wr(input logic [AIS_AW-1:0] a, input logic [AIS_DW-1:0] d);
    @(negedge clk);
    req = '{rd_en: 1'b0, wr_en: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    req = '{rd_en: 1'b0, wr_en: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr

  task automatic rd(input logic [AIS_AW-1:0] a, output logic [AIS_DW-1:0] d, output logic v);
    @(negedge clk);
    req = '{rd_en: 1'b1, wr_en: 1'b0, addr: a, wdata: req.wdata};
    @(negedge clk);
    req.rd_en = 1'b0;
    req.addr = ~a;
    v = rd_valid_q;
    d = rd_data_q;
  endtask : rd
endmodule : ais_host

// ==== tb/ais_regs_tb.sv ====
// Self-checking bench for the identification and status register bank
`timescale 1ns/100ps
module ais_regs_tb
  import ais_pkg::*;
;
  logic clk;
  logic rst_n = 1'b0;
  ais_req_t req;
  logic spi_locked = 1'b0;
  logic resync_pulse = 1'b0;
  logic crc_err_pulse = 1'b0;
  logic crc_type_sel = 1'b0;
  logic register_map_checksum_valid = 1'b0;
  logic [1:0] word_size_sel = 2'h1;
  logic [15:0] register_map_checksum = 16'h0000;
  logic [3:0] sample_pulse = 4'h0;
  logic [3:0] sample_taken = 4'h0;
  logic [15:0] rd_data_q;
  logic [15:0] status_q;
  logic rd_valid_q;
  logic [15:0] o_g2h, o_g2l, o_o3h, o_o3l, o_g3h, o_g3l;
  logic [1:0] o_sel;
  int n_fail = 0;
  int n_tests = 0;
  logic [15:0] m_reg [64];
  logic [15:0] m_crc;
  logic m_seen, m_lock, m_rs, m_rm, m_ce, m_ct, m_rst;
  logic [1:0] m_ws;
  logic [3:0] m_ns;
  logic [5:0] addrs [11] = '{6'h00, 6'h01, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C,
    6'h3E, 6'h20};

  ais_host host (.clk(clk), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .req(req));

  ais_regs uut (.clk(clk), .rst_n(rst_n), .rd_en(req.rd_en), .wr_en(req.wr_en),
    .addr(req.addr), .wdata(req.wdata), .spi_locked(spi_locked), .resync_pulse(resync_pulse),
    .crc_err_pulse(crc_err_pulse), .crc_type_sel(crc_type_sel), .word_size_sel(word_size_sel),
    .register_map_checksum(register_map_checksum), .register_map_checksum_valid(register_map_checksum_valid), .sample_pulse(sample_pulse),
    .sample_taken(sample_taken), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .status_q(status_q), .ch2_gain_cal_high_q(o_g2h), .ch2_gain_cal_low_q(o_g2l),
    .ch3_input_select_q(o_sel), .ch3_offset_cal_upper_q(o_o3h), .ch3_offset_cal_low_q(o_o3l),
    .ch3_gain_cal_upper_q(o_g3h), .ch3_gain_cal_low_q(o_g3l));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic m_init();
    m_reg = '{default: 16'h0000};
    m_reg[6'h16] = 16'h8000;
    m_reg[6'h1B] = 16'h8000;
    {m_lock, m_rs, m_rm, m_ce, m_ct, m_rst, m_ws, m_ns} = {6'b000001, 2'b01, 4'h0};
    m_crc = 16'h0000;
    m_seen = 1'b0;
  endtask : m_init

  task automatic rd_chk(input logic [5:0] a);
    logic [15:0] d;
    logic [15:0] e;
    logic v;
    host.rd(a, d, v);
    e = (a == OFS_STATUS) ? {m_lock, m_rs, m_rm, m_ce, m_ct, m_rst, m_ws, 4'h0, m_ns} : m_reg[a];
    if (a == OFS_REGISTER_MAP_CHECKSUM)
      e = m_crc;
    chk("read valid", 16'h0001, {15'h0000, v});
    // Low identification byte is version dependent
    if (a == OFS_IDENT)
      chk("identification", 16'h4400, d & 16'hFF00);
    else
      chk($sformatf("register %h", a), e, d);
    // Calibration outputs must match what the host reads back
    case (a)
      OFS_CH2_GCAL_HI: chk("ch2 gain high output", e, o_g2h);
      OFS_CH2_GCAL_LO: chk("ch2 gain low output", e, o_g2l);
      OFS_CH3_INPUT_CONFIG: chk("ch3 select output", e, {14'h0000, o_sel});
      OFS_CH3_OCAL_HI: chk("ch3 offset high output", e, o_o3h);
      OFS_CH3_OCAL_LO: chk("ch3 offset low output", e, o_o3l);
      OFS_CH3_GCAL_HI: chk("ch3 gain high output", e, o_g3h);
      OFS_CH3_GCAL_LO: chk("ch3 gain low output", e, o_g3l);
      default: ;
    endcase
    if (a == OFS_STATUS)
      {m_rs, m_rm, m_ce} = 3'b000;
  endtask : rd_chk

  task automatic wr_m(input logic [5:0] a, input logic [15:0] d);
    host.wr(a, d);
    case (a)
      6'h16, 6'h19, 6'h1B: m_reg[a] = d;
      6'h17, 6'h1A, 6'h1C: m_reg[a] = d & 16'hFF00;
      6'h18: m_reg[a] = d & 16'h0003;
      OFS_MODE: m_rst = m_rst & d[10];
      default: ;
    endcase
  endtask : wr_m

  // sel bits: 0 resync, 1 checksum error, 2 register-map checksum update
  task automatic ev(input logic [2:0] sel, input logic [3:0] ns, input logic [3:0] tk,
    input logic [15:0] crc);
    @(negedge clk);
    {register_map_checksum_valid, crc_err_pulse, resync_pulse} = sel;
    {sample_pulse, sample_taken, register_map_checksum} = {ns, tk, crc};
    @(negedge clk);
    {register_map_checksum_valid, crc_err_pulse, resync_pulse, sample_pulse, sample_taken} = '0;
    register_map_checksum = ~crc;
    m_rs |= sel[0];
    m_ce |= sel[1];
    m_ns = (m_ns & ~tk) | ns;
    if (sel[2])
    begin
      m_rm |= m_seen && crc != m_crc;
      m_crc = crc;
      m_seen = 1'b1;
    end
    @(negedge clk);
  endtask : ev

  initial
  begin
    #1000000;
    n_fail++;
    summarize();
  end

  initial
  begin
    logic [15:0] c;
    void'($urandom(32'hDC701942));
    m_init();
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    foreach (addrs[i]) rd_chk(addrs[i]);
    $display("test reset values done");
    foreach (addrs[i])
    begin
      wr_m(addrs[i], 16'($urandom));
      rd_chk(addrs[i]);
    end
    wr_m(OFS_STATUS, 16'hFFFF);
    rd_chk(OFS_STATUS);
    $display("test writes done");
    for (int w = 0; w < 4; w++)
    begin
      {spi_locked, crc_type_sel, word_size_sel} = {w[0], ~w[1], w[1:0]};
      {m_lock, m_ct, m_ws} = {w[0], ~w[1], w[1:0]};
      ev(3'b000, 4'h0, 4'h0, 16'h0000);
      rd_chk(OFS_STATUS);
    end
    $display("test status levels done");
    ev(3'b011, 4'hA, 4'h0, 16'h0000);
    rd_chk(OFS_STATUS);
    ev(3'b000, 4'h1, 4'h9, 16'h0000);
    rd_chk(OFS_STATUS);
    c = 16'($urandom);
    ev(3'b100, 4'h0, 4'h0, c);
    rd_chk(OFS_STATUS);
    ev(3'b100, 4'h0, 4'h0, c);
    rd_chk(OFS_STATUS);
    ev(3'b100, 4'h0, 4'h0, c ^ 16'h0100);
    rd_chk(OFS_STATUS);
    rd_chk(OFS_REGISTER_MAP_CHECKSUM);
    $display("test status events done");
    wr_m(OFS_MODE, 16'h0400);
    rd_chk(OFS_STATUS);
    wr_m(OFS_MODE, 16'h0000);
    rd_chk(OFS_STATUS);
    $display("test reset flag done");
    {spi_locked, crc_type_sel, word_size_sel} = 4'h1;
    @(negedge clk);
    rst_n = 1'b0;
    m_init();
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(OFS_STATUS);
    $display("test second reset done");
    summarize();
  end
endmodule : ais_regs_tb
